// >>> pbf_pkg.sv
package pbf_pkg;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int NPIN   = 14;
   localparam int N_BUS_CTL  = 12;
   localparam int BUS_CTL_LO = 2;

   localparam logic [ADDR_W-1:0] OFS_SEL1 = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SEL2 = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_DIR  = 4'h8;

   localparam logic [DATA_W-1:0] SEL1_MASK = 16'h0555;
   localparam logic [DATA_W-1:0] SEL2_MASK = 16'h5555;
   localparam logic [DATA_W-1:0] DIR_MASK  = 16'h3FFF;
   localparam logic [DATA_W-1:0] REG_RST   = 16'h0000;
   localparam logic [DATA_W-1:0] RD_IDLE   = 16'h0000;

   localparam int B1_P13 = 10;
   localparam int B1_P12 = 8;
   localparam int B1_P11 = 6;
   localparam int B1_P10 = 4;
   localparam int B1_P9  = 2;
   localparam int B1_P8  = 0;
   localparam int B2_P7  = 14;
   localparam int B2_P6  = 12;
   localparam int B2_P5  = 10;
   localparam int B2_P4  = 8;
   localparam int B2_P3  = 6;
   localparam int B2_P2  = 4;
   localparam int B2_P1  = 2;
   localparam int B2_P0  = 0;

   localparam int P_WIDTH16 = 1;
   localparam int P_WAIT    = 0;

   // Bus controller outputs, pin 13 down to pin 2.
   typedef struct packed {
      logic bus_start_strobe;
      logic chip_select_three;
      logic chip_select_four;
      logic chip_select_five_b;
      logic card_enable_two_a;
      logic chip_select_six_b;
      logic card_enable_two_b;
      logic card_io_write_strobe;
      logic card_io_read_strobe;
      logic row_addr_strobe;
      logic col_addr_strobe;
      logic clock_enable;
   } pbf_bus_ctl_s;

   typedef struct packed {
      logic [NPIN-1:0] o;
      logic [NPIN-1:0] oe;
   } pbf_pin_s;

   typedef struct packed {
      logic [DATA_W-1:0] sel1;
      logic [DATA_W-1:0] sel2;
      logic [DATA_W-1:0] dir;
      logic [DATA_W-1:0] rdata;
      pbf_pin_s          pin;
      logic [NPIN-1:0]   gp_in;
      logic              width16;
      logic              wait_req;
   } pbf_state_s;

endpackage : pbf_pkg

// >>> pbf_port_b_pin_function_select.sv
`timescale 1ns/100ps
module pbf_port_b_pin_function_select (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   input  wire logic                          ce,
   input  wire logic [pbf_pkg::ADDR_W-1:0]    addr,
   input  wire logic [pbf_pkg::DATA_W-1:0]    wr_data,
   input  wire logic                          wr_stb,
   input  wire logic                          rd_stb,
   output logic      [pbf_pkg::DATA_W-1:0]    rd_data,
   input  wire logic [pbf_pkg::NPIN-1:0]      pin_in,
   output pbf_pkg::pbf_pin_s                  pin_drv,
   input  wire logic [pbf_pkg::NPIN-1:0]      gp_out,
   output logic      [pbf_pkg::NPIN-1:0]      gp_in,
   input  wire pbf_pkg::pbf_bus_ctl_s         bus_ctl_val,
   input  wire pbf_pkg::pbf_bus_ctl_s         bus_ctl_en,
   output logic                               io_width16_indication,
   output logic                               wait_request
);
   import pbf_pkg::*;

   pbf_state_s      st_ff;
   pbf_state_s      nxt_st;
   logic [NPIN-1:0] mode;
   logic [NPIN-1:0] bus_o;
   logic [NPIN-1:0] bus_oe;

   // Padding the two input-function pins lets one index serve pin and bus side alike.
   assign bus_o  = {bus_ctl_val, {BUS_CTL_LO{1'b0}}};
   assign bus_oe = {bus_ctl_en, {BUS_CTL_LO{1'b0}}};

   assign mode[13] = st_ff.sel1[B1_P13];
   assign mode[12] = st_ff.sel1[B1_P12];
   assign mode[11] = st_ff.sel1[B1_P11];
   assign mode[10] = st_ff.sel1[B1_P10];
   assign mode[9]  = st_ff.sel1[B1_P9];
   assign mode[8]  = st_ff.sel1[B1_P8];
   assign mode[7]  = st_ff.sel2[B2_P7];
   assign mode[6]  = st_ff.sel2[B2_P6];
   assign mode[5]  = st_ff.sel2[B2_P5];
   assign mode[4]  = st_ff.sel2[B2_P4];
   assign mode[3]  = st_ff.sel2[B2_P3];
   assign mode[2]  = st_ff.sel2[B2_P2];
   assign mode[1]  = st_ff.sel2[B2_P1];
   assign mode[0]  = st_ff.sel2[B2_P0];

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rdata = RD_IDLE;
      // Masking at the write keeps reserved bits zero in storage as well.
      if (wr_stb) begin
         case (addr)
            OFS_SEL1: nxt_st.sel1 = wr_data & SEL1_MASK;
            OFS_SEL2: nxt_st.sel2 = wr_data & SEL2_MASK;
            OFS_DIR:  nxt_st.dir  = wr_data & DIR_MASK;
            default:  nxt_st.sel1 = st_ff.sel1;
         endcase
      end
      if (rd_stb) begin
         case (addr)
            OFS_SEL1: nxt_st.rdata = st_ff.sel1 & SEL1_MASK;
            OFS_SEL2: nxt_st.rdata = st_ff.sel2 & SEL2_MASK;
            OFS_DIR:  nxt_st.rdata = st_ff.dir & DIR_MASK;
            default:  nxt_st.rdata = RD_IDLE;
         endcase
      end
      for (int i = 0; i < NPIN; i++) begin
         if (!mode[i]) begin
            nxt_st.pin.o[i]  = gp_out[i];
            nxt_st.pin.oe[i] = st_ff.dir[i];
         end else if (i >= BUS_CTL_LO) begin
            nxt_st.pin.o[i]  = bus_o[i];
            nxt_st.pin.oe[i] = bus_oe[i];
         end else begin
            // Input functions never drive the pin.
            nxt_st.pin.o[i]  = 1'b0;
            nxt_st.pin.oe[i] = 1'b0;
         end
      end
      // The port input latch keeps sampling in every function, so
      // software can still observe a pin owned by the bus controller.
      nxt_st.gp_in = pin_in;
      // An unselected input reads inactive high at the bus controller.
      nxt_st.width16  = mode[P_WIDTH16] ? pin_in[P_WIDTH16] : 1'b1;
      nxt_st.wait_req = mode[P_WAIT] ? pin_in[P_WAIT] : 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff.sel1     <= REG_RST;
         st_ff.sel2     <= REG_RST;
         st_ff.dir      <= REG_RST;
         st_ff.rdata    <= RD_IDLE;
         st_ff.pin      <= '0;
         st_ff.gp_in    <= '0;
         st_ff.width16  <= 1'b1;
         st_ff.wait_req <= 1'b1;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data               = st_ff.rdata;
   assign pin_drv               = st_ff.pin;
   assign gp_in                 = st_ff.gp_in;
   assign io_width16_indication = st_ff.width16;
   assign wait_request          = st_ff.wait_req;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_WR_SEL1: assert property (
      (ce && wr_stb && addr == OFS_SEL1)
      |=> (st_ff.sel1 == ($past(wr_data) & SEL1_MASK)))
      else $error("first select register not written");

   AST_WR_SEL2: assert property (
      (ce && wr_stb && addr == OFS_SEL2)
      |=> (st_ff.sel2 == ($past(wr_data) & SEL2_MASK)))
      else $error("second select register not written");

   AST_RSV_READ: assert property (
      (ce && rd_stb && (addr == OFS_SEL1 || addr == OFS_SEL2))
      |=> ((rd_data & ~(SEL1_MASK | SEL2_MASK)) == '0))
      else $error("reserved bits read nonzero");

   AST_RD_SEL1: assert property (
      (ce && rd_stb && addr == OFS_SEL1)
      |=> (rd_data == $past(st_ff.sel1)))
      else $error("first select readback wrong");

   AST_RD_ONCE: assert property (
      (ce && !rd_stb) |=> (rd_data == RD_IDLE))
      else $error("read data held too long");

   // A bus-owned pin copies value and enable from the bus controller one cycle later.
   AST_PIN13_BUS: assert property (
      (ce && mode[13])
      |=> (pin_drv.o[13] == $past(bus_ctl_val.bus_start_strobe)
           && pin_drv.oe[13] == $past(bus_ctl_en.bus_start_strobe)))
      else $error("pin 13 not driven by bus start strobe");

   AST_PIN12_BUS: assert property (
      (ce && mode[12])
      |=> (pin_drv.o[12] == $past(bus_ctl_val.chip_select_three)
           && pin_drv.oe[12] == $past(bus_ctl_en.chip_select_three)))
      else $error("pin 12 not driven by chip select three");

   AST_PIN11_BUS: assert property (
      (ce && mode[11])
      |=> (pin_drv.o[11] == $past(bus_ctl_val.chip_select_four)
           && pin_drv.oe[11] == $past(bus_ctl_en.chip_select_four)))
      else $error("pin 11 not driven by chip select four");

   AST_PIN10_BUS: assert property (
      (ce && mode[10])
      |=> (pin_drv.o[10] == $past(bus_ctl_val.chip_select_five_b)
           && pin_drv.oe[10] == $past(bus_ctl_en.chip_select_five_b)))
      else $error("pin 10 not driven by chip select five B");

   AST_PIN9_BUS: assert property (
      (ce && mode[9])
      |=> (pin_drv.o[9] == $past(bus_ctl_val.card_enable_two_a)
           && pin_drv.oe[9] == $past(bus_ctl_en.card_enable_two_a)))
      else $error("pin 9 not driven by card enable two A");

   AST_PIN8_BUS: assert property (
      (ce && mode[8])
      |=> (pin_drv.o[8] == $past(bus_ctl_val.chip_select_six_b)
           && pin_drv.oe[8] == $past(bus_ctl_en.chip_select_six_b)))
      else $error("pin 8 not driven by chip select six B");

   AST_PIN7_BUS: assert property (
      (ce && mode[7])
      |=> (pin_drv.o[7] == $past(bus_ctl_val.card_enable_two_b)
           && pin_drv.oe[7] == $past(bus_ctl_en.card_enable_two_b)))
      else $error("pin 7 not driven by card enable two B");

   AST_PIN6_BUS: assert property (
      (ce && mode[6])
      |=> (pin_drv.o[6] == $past(bus_ctl_val.card_io_write_strobe)
           && pin_drv.oe[6] == $past(bus_ctl_en.card_io_write_strobe)))
      else $error("pin 6 not driven by card I/O write strobe");

   AST_PIN5_BUS: assert property (
      (ce && mode[5])
      |=> (pin_drv.o[5] == $past(bus_ctl_val.card_io_read_strobe)
           && pin_drv.oe[5] == $past(bus_ctl_en.card_io_read_strobe)))
      else $error("pin 5 not driven by card I/O read strobe");

   AST_PIN4_BUS: assert property (
      (ce && mode[4])
      |=> (pin_drv.o[4] == $past(bus_ctl_val.row_addr_strobe)
           && pin_drv.oe[4] == $past(bus_ctl_en.row_addr_strobe)))
      else $error("pin 4 not driven by row address strobe");

   AST_PIN3_BUS: assert property (
      (ce && mode[3])
      |=> (pin_drv.o[3] == $past(bus_ctl_val.col_addr_strobe)
           && pin_drv.oe[3] == $past(bus_ctl_en.col_addr_strobe)))
      else $error("pin 3 not driven by column address strobe");

   AST_PIN2_BUS: assert property (
      (ce && mode[2])
      |=> (pin_drv.o[2] == $past(bus_ctl_val.clock_enable)
           && pin_drv.oe[2] == $past(bus_ctl_en.clock_enable)))
      else $error("pin 2 not driven by memory clock enable");

   // The release edge is still clocked as reset, so the rst_n term keeps it out of
   // the antecedents of AST_PORT_DIR, AST_PORT_ALL, AST_INPUT_FN_QUIET and AST_GP_IN, whose consequents compare against sampled inputs.
   AST_PORT_DIR: assert property (
      (rst_n && ce && !mode[6])
      |=> (pin_drv.oe[6] == $past(st_ff.dir[6])
           && pin_drv.o[6] == $past(gp_out[6])))
      else $error("pin 6 port direction not applied");

   // The mode masks the direction bits, so a bus-owned pin never follows them.
   AST_PORT_ALL: assert property (
      (rst_n && ce)
      |=> ((pin_drv.oe & ~$past(mode)) == ($past(st_ff.dir[NPIN-1:0]) & ~$past(mode))
           && (pin_drv.o & ~$past(mode)) == ($past(gp_out) & ~$past(mode))))
      else $error("port function pins not following direction and data");

   AST_INPUT_FN_QUIET: assert property (
      (rst_n && ce)
      |=> ((pin_drv.oe[P_WIDTH16:P_WAIT] & $past(mode[P_WIDTH16:P_WAIT])) == '0))
      else $error("input function pin driven");

   AST_GP_IN: assert property (
      (rst_n && ce) |=> (gp_in == $past(pin_in)))
      else $error("port input copy wrong");

   AST_WIDTH16_IDLE: assert property (
      (ce && !mode[P_WIDTH16]) |=> io_width16_indication)
      else $error("16-bit indication not inactive while unselected");

   AST_WAIT_IDLE: assert property (
      (ce && !mode[P_WAIT]) |=> wait_request)
      else $error("wait request not inactive while unselected");

   AST_WR_DIR: assert property (
      (rst_n && ce && wr_stb && addr == OFS_DIR)
      |=> (st_ff.dir == ($past(wr_data) & DIR_MASK)))
      else $error("direction register not written");

   AST_WR_UNMAPPED: assert property (
      (rst_n && ce && wr_stb && addr != OFS_SEL1 && addr != OFS_SEL2 && addr != OFS_DIR)
      |=> ($stable(st_ff.sel1) && $stable(st_ff.sel2) && $stable(st_ff.dir)))
      else $error("write to unmapped address changed a register");

   AST_RD_SEL2: assert property (
      (rst_n && ce && rd_stb && addr == OFS_SEL2)
      |=> (rd_data == $past(st_ff.sel2)))
      else $error("second select readback wrong");

   AST_RD_DIR: assert property (
      (rst_n && ce && rd_stb && addr == OFS_DIR)
      |=> (rd_data == $past(st_ff.dir)))
      else $error("direction readback wrong");

   AST_RD_UNMAPPED: assert property (
      (rst_n && ce && rd_stb && addr != OFS_SEL1 && addr != OFS_SEL2 && addr != OFS_DIR)
      |=> (rd_data == RD_IDLE))
      else $error("unmapped read returned data");

   AST_RSV_SEL1: assert property (
      (ce && rd_stb && addr == OFS_SEL1)
      |=> ((rd_data & ~SEL1_MASK) == '0))
      else $error("first select reserved bits read nonzero");

   AST_RSV_SEL2: assert property (
      (ce && rd_stb && addr == OFS_SEL2)
      |=> ((rd_data & ~SEL2_MASK) == '0))
      else $error("second select reserved bits read nonzero");

   AST_RSV_DIR: assert property (
      (ce && rd_stb && addr == OFS_DIR)
      |=> ((rd_data & ~DIR_MASK) == '0))
      else $error("direction reserved bits read nonzero");

   AST_FREEZE_PIN: assert property (
      !ce |=> ($stable(pin_drv) && $stable(rd_data)))
      else $error("outputs changed with clock enable low");

   // Pads may face live devices before software runs, so outputs must idle at once.
   AST_RESET_OUT: assert property (
      $rose(rst_n)
      |-> (rd_data == RD_IDLE && pin_drv == '0 && gp_in == '0
           && io_width16_indication && wait_request))
      else $error("outputs not at reset values after reset");

   AST_WIDTH16_IN: assert property (
      (ce && mode[P_WIDTH16])
      |=> (io_width16_indication == $past(pin_in[P_WIDTH16])
           && !pin_drv.oe[P_WIDTH16]))
      else $error("16-bit indication not routed");

   AST_WAIT_IN: assert property (
      (ce && mode[P_WAIT]) ##1 (ce && mode[P_WAIT])
      |=> (wait_request == $past(pin_in[P_WAIT]) && !pin_drv.oe[P_WAIT]))
      else $error("wait request not routed");

   AST_RESET_PORT: assert property (
      $rose(rst_n) |-> (mode == '0))
      else $error("mode bits not clear after reset");

   AST_FREEZE: assert property (
      !ce |=> $stable(st_ff))
      else $error("state changed with clock enable low");

   COV_SEL_WRITE: cover property (
      (ce && wr_stb && addr == OFS_SEL1) ##1 (ce && rd_stb && addr == OFS_SEL1));

   COV_BUS_PIN: cover property (
      (ce && mode[13] && bus_ctl_en.bus_start_strobe) ##1 pin_drv.oe[13]);

   COV_WAIT_SEL: cover property (
      (ce && mode[P_WAIT]) ##1 (ce && !pin_in[P_WAIT]) ##1 !wait_request);

   COV_PORT_OUT: cover property (
      (ce && !mode[2] && st_ff.dir[2]) ##1 pin_drv.oe[2]);

endmodule : pbf_port_b_pin_function_select

// >>> pbf_pad_model.sv
`timescale 1ns/100ps
// Far-side memories and bus devices: a released pad takes a fresh random pattern every cycle,
// so a stale value passes for a routed one only when a random bit happens to repeat.
module pbf_pad_model (
   input  wire logic                     ref_clk,
   input  wire pbf_pkg::pbf_pin_s        pin_drv,
   output logic [pbf_pkg::NPIN-1:0]      pin_in
);
   import pbf_pkg::*;
   logic [NPIN-1:0] ext_ff = '0;
   always @(posedge ref_clk) begin
      ext_ff <= NPIN'($urandom);
   end
   assign pin_in = (pin_drv.oe & pin_drv.o) | (~pin_drv.oe & ext_ff);
endmodule : pbf_pad_model

// >>> test_port_b_pin_function_select.sv
`timescale 1ns/100ps
module test_port_b_pin_function_select;
   import pbf_pkg::*;
   logic              ref_clk = 0, rst_n = 0, ce = 1, wr_stb = 0, rd_stb = 0;
   logic [ADDR_W-1:0] addr = '0, ra;
   logic [DATA_W-1:0] wr_data = '0, rd_data, m_s1, m_s2, m_dir, e_rd;
   logic [NPIN-1:0]   pin_in, gp_out = '0, gp_in, e_gi, e_o, e_oe, e_om;
   logic              w16, wrq, e_w16, e_wrq, m;
   pbf_pin_s          pin_drv;
   pbf_bus_ctl_s      bus_ctl_val = '0, bus_ctl_en = '0;
   int                num_errors = 0, n_checks = 0, cyc = 0, i;
   logic [ADDR_W-1:0] ads [4] = '{OFS_SEL1, OFS_SEL2, OFS_DIR, 4'hC};

   always #5 ref_clk = ~ref_clk;

   pbf_port_b_pin_function_select dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .pin_in(pin_in), .pin_drv(pin_drv), .gp_out(gp_out), .gp_in(gp_in),
      .bus_ctl_val(bus_ctl_val), .bus_ctl_en(bus_ctl_en),
      .io_width16_indication(w16), .wait_request(wrq));
   pbf_pad_model pad (.ref_clk(ref_clk), .pin_drv(pin_drv), .pin_in(pin_in));

   // Reference model: reads the inputs as they stood before each edge.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {m_s1, m_s2, m_dir, e_rd, e_o, e_oe, e_gi} = '0;
         {e_w16, e_wrq} = 2'h3;
         e_om = '1;
      end else if (ce) begin
         for (int p = 0; p < NPIN; p++) begin
            m = (p > 7) ? m_s1[2*(p-8)] : m_s2[2*p];
            e_om[p] = !(p < 2 && m);
            e_o[p] = m ? ((p > 1) ? bus_ctl_val[p-BUS_CTL_LO] : 1'b0) : gp_out[p];
            e_oe[p] = m ? ((p > 1) ? bus_ctl_en[p-BUS_CTL_LO] : 1'b0) : m_dir[p];
         end
         e_gi = pin_in;
         e_w16 = m_s2[2] ? pin_in[1] : 1'b1;
         e_wrq = m_s2[0] ? pin_in[0] : 1'b1;
         e_rd = '0;
         if (rd_stb) begin
            e_rd = (addr == OFS_SEL1) ? m_s1 : (addr == OFS_SEL2) ? m_s2 :
                   (addr == OFS_DIR) ? m_dir : 16'h0000;
         end
         if (wr_stb && addr == OFS_SEL1) m_s1 = wr_data & SEL1_MASK;
         if (wr_stb && addr == OFS_SEL2) m_s2 = wr_data & SEL2_MASK;
         if (wr_stb && addr == OFS_DIR) m_dir = wr_data & DIR_MASK;
      end
   end

   task automatic chk(string nm, logic [DATA_W-1:0] e, logic [DATA_W-1:0] s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   always @(negedge ref_clk) begin
      if (cyc > 0) begin
         chk("rd_data", e_rd, rd_data);
         chk("pin_o", DATA_W'(e_o & e_om), DATA_W'(pin_drv.o & e_om));
         chk("pin_oe", DATA_W'(e_oe), DATA_W'(pin_drv.oe));
         chk("gp_in", DATA_W'(e_gi), DATA_W'(gp_in));
         chk("width16", DATA_W'(e_w16), DATA_W'(w16));
         chk("wait", DATA_W'(e_wrq), DATA_W'(wrq));
      end
   end

   // Bus and pad side inputs change just after each edge.
   always @(posedge ref_clk) begin
      gp_out <= NPIN'($urandom);
      bus_ctl_val <= N_BUS_CTL'($urandom);
      bus_ctl_en <= N_BUS_CTL'($urandom);
   end

   // Software writes zero to reserved bits; unmapped addresses take anything.
   function automatic logic [DATA_W-1:0] legal(logic [ADDR_W-1:0] a);
      return (a == OFS_SEL1) ? SEL1_MASK : (a == OFS_SEL2) ? SEL2_MASK :
             (a == OFS_DIR) ? DIR_MASK : 16'hFFFF;
   endfunction : legal

   task automatic drive(logic c, logic w, logic r, logic [ADDR_W-1:0] a, logic [15:0] d);
      ce <= c;
      wr_stb <= w;
      rd_stb <= r;
      addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
   endtask : drive

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   // The ceiling leaves room over the roughly 1020 cycles the tests need.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         close_out();
      end
   end

   initial begin
      void'($urandom(32'hE170));
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i++) drive(1, 0, 1, ads[i], 16'h0000);
      $display("test reset_values done");
      for (i = 0; i < 4; i++) begin
         drive(1, 1, 0, ads[i], legal(ads[i]));
         drive(1, 0, 1, ads[i], 16'h0000);
      end
      $display("test reserved_bits done");
      // Software keeps reserved bits zero here; ce drops now and then to freeze state.
      repeat (1000) begin
         i = $urandom % 3;
         ra = ads[$urandom % 4];
         drive(($urandom % 8) != 0, i == 1, i == 2, ra, 16'($urandom) & legal(ra));
      end
      $display("test random_traffic done");
      rst_n <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 3; i++) drive(1, 0, 1, ads[i], 16'h0000);
      drive(1, 0, 0, 4'h0, 16'h0000);
      $display("test mid_reset done");
      close_out();
   end
endmodule : test_port_b_pin_function_select
